// ---- rtl/lcdr_pkg.sv ----
// Constants and types shared by the LCD controller register bank
package lcdr_pkg;

  // ---------------------------------------------------------------
  // Register numbers reached through the index register
  // ---------------------------------------------------------------
  localparam logic [4:0] IDX_CONTROL_ONE = 5'h00;
  localparam logic [4:0] IDX_CONTROL_TWO = 5'h01;
  localparam logic [4:0] IDX_COLUMN_ADDR = 5'h02;
  localparam logic [4:0] IDX_LINE_ADDR = 5'h03;
  localparam logic [4:0] IDX_RAM_DATA = 5'h04;
  localparam logic [4:0] IDX_TOP_RASTER = 5'h05;
  localparam logic [4:0] IDX_FLASH_FIRST = 5'h06;
  localparam logic [4:0] IDX_FLASH_LAST = 5'h07;
  localparam logic [4:0] REG_COUNT = 5'h12;

  // ---------------------------------------------------------------
  // Field layouts, most significant bit first
  // ---------------------------------------------------------------
  typedef struct packed {
    logic write_only_step;
    logic panel_on;
    logic sleep_mode;
    logic ext_supply_ctl;
    logic bias_amp_en;
    logic invert_pixels;
    logic freeze_internal;
    logic column_reverse;
  } lcdr_ctl1_t;

  typedef struct packed {
    logic [1:0] divider_ratio;
    logic word_size_sel;
    logic grey_fixed;
    logic [1:0] duty_sel;
    logic step_column;
    logic flash_enable;
  } lcdr_ctl2_t;

  // Decoded drive settings handed to the scan logic
  typedef struct packed {
    logic [3:0] bias_denominator;
    logic [6:0] duty_rows;
    logic partial_mode;
    logic grey_fixed;
    logic invert_pixels;
    logic column_reverse;
    logic six_bit_words;
  } lcdr_drive_t;

  // ---------------------------------------------------------------
  // Reset values and limits
  // ---------------------------------------------------------------
  localparam lcdr_ctl1_t CTL1_RESET = 8'h00;
  localparam lcdr_ctl2_t CTL2_RESET = 8'h00;
  localparam logic [4:0] INDEX_RESET = 5'h00;
  localparam logic [5:0] COLUMN_RESET = 6'h00;
  localparam logic [6:0] RASTER_RESET = 7'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [5:0] COLUMN_MAX_8BIT = 6'h27;
  localparam logic [5:0] COLUMN_MAX_6BIT = 6'h35;
  localparam logic [6:0] LINE_MAX = 7'h40;
  localparam logic [5:0] FLASH_FRAMES_LAST = 6'h3F;

  // Bias and duty encodings
  localparam logic [3:0] BIAS_DIV_8 = 4'h8;
  localparam logic [3:0] BIAS_DIV_9 = 4'h9;
  localparam logic [3:0] BIAS_DIV_10 = 4'hA;
  localparam logic [3:0] BIAS_DIV_11 = 4'hB;
  localparam logic [6:0] DUTY_ROWS_8 = 7'h08;
  localparam logic [6:0] DUTY_ROWS_64 = 7'h40;
  localparam logic [6:0] DUTY_ROWS_80 = 7'h50;
  localparam logic [6:0] DUTY_ROWS_100 = 7'h64;

  // Host access sequencer, Gray coded along idle-read-fetch
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_WRITE = 2'b01,
    HS_READ = 2'b10,
    HS_FETCH = 2'b11
  } lcdr_hs_t;

endpackage

// ---- rtl/lcdr_top.sv ----
// Host register bank of the grey-scale dot-matrix LCD controller
//
// Behaviour
// - Chip init low clears every register
// - Host accesses ignored while chip init low
// - Reset holds drivers off, no alternation
// - Index written with select low picks register
// - Write-only registers; unused writes do nothing
// - Write-only-step advances address only on writes
// - Panel off forces drivers to drive level
// - Sleep halts operation, oscillator and display
// - Supply control bit drives supply switch pin
// - Bias amplifier enable and pixel inversion bits
// - Freeze bit stops internal operation
// - Column order bit reverses column mapping
// - Flash enable clear resets blink counter
// - Divider ratio field selects drive bias
// - Word size bit selects six or eight
// - Grey bit fixes four levels
// - Duty field selects multiplex duty
// - Step bit picks column or line advance
// - Column address limit depends on word size
// - Line address above limit is ignored
// - RAM reads return previously latched data
// - Top raster register scrolls the display
// - Flash area toggles every 64 frames
// - Sleep keeps data, only control writes
`timescale 1ns/1ps
`default_nettype none

module lcdr_top (
  // Clock, reset, enable
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Chip init pin, active low
  input wire logic i_chip_init_n,
  // Host parallel bus
  input wire logic i_cs_n,
  input wire logic i_reg_select,
  input wire logic i_wr_n,
  input wire logic i_rd_n,
  input wire logic [7:0] i_data,
  output logic [7:0] o_data,
  output logic o_data_oe,
  // Display RAM port, one cycle read latency
  output logic [5:0] o_ram_column,
  output logic [6:0] o_ram_line,
  output logic o_ram_wr,
  output logic [7:0] o_ram_wdata,
  output logic o_ram_rd,
  input wire logic [7:0] i_ram_rdata,
  // Scan timing
  input wire logic i_frame_tick,
  // Drive control
  output logic o_drivers_off,
  output logic o_alternate_hold,
  output logic o_osc_run,
  output logic o_internal_run,
  output logic o_supply_switch_out,
  output logic o_bias_amp_en,
  output logic o_flash_blank,
  output lcdr_pkg::lcdr_drive_t o_drive,
  output logic [6:0] o_top_raster,
  output logic [6:0] o_flash_first,
  output logic [6:0] o_flash_last
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  lcdr_pkg::lcdr_hs_t hs_state;
  logic hs_rs;
  logic [7:0] hs_wdata;
  logic [4:0] index_select;
  lcdr_pkg::lcdr_ctl1_t control_one;
  lcdr_pkg::lcdr_ctl2_t control_two;
  logic [5:0] column_address;
  logic [6:0] line_address;
  logic [6:0] top_raster;
  logic [6:0] flash_first_raster;
  logic [6:0] flash_last_raster;
  logic [7:0] read_latch;
  logic [5:0] flash_count;
  logic flash_phase;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic in_init;
  logic bus_wr;
  logic bus_rd;
  logic commit_wr;
  logic commit_index;
  logic commit_data;
  logic ram_selected;
  logic data_reg_open;
  logic ram_access_wr;
  logic [5:0] column_limit;
  logic [7:0] wmasked;
  logic running;
  lcdr_pkg::lcdr_ctl1_t next_control_one;

  assign in_init = ~i_chip_init_n;
  assign bus_wr = ~i_cs_n & ~i_wr_n;
  assign bus_rd = ~i_cs_n & ~i_rd_n;
  // Commit only at the end of the strobe so a register changes in one cycle
  assign commit_wr = (hs_state == lcdr_pkg::HS_WRITE) & ~bus_wr;
  assign commit_index = commit_wr & ~hs_rs;
  assign commit_data = commit_wr & hs_rs;
  assign ram_selected = (index_select == lcdr_pkg::IDX_RAM_DATA);
  // In sleep only the two control registers stay reachable
  assign data_reg_open = ~control_one.sleep_mode |
                         (index_select == lcdr_pkg::IDX_CONTROL_ONE) |
                         (index_select == lcdr_pkg::IDX_CONTROL_TWO);
  assign ram_access_wr = commit_data & ram_selected & data_reg_open;
  assign column_limit = control_two.word_size_sel ? lcdr_pkg::COLUMN_MAX_6BIT :
                        lcdr_pkg::COLUMN_MAX_8BIT;
  // Six-bit words clear the top two bits so RAM never keeps stale ones
  assign wmasked = control_two.word_size_sel ? {2'b00, hs_wdata[5:0]} : hs_wdata;
  assign running = ~control_one.sleep_mode & ~control_one.freeze_internal;

  // ---------------------------------------------------------------
  // Host access sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      hs_state <= lcdr_pkg::HS_IDLE;
      hs_rs <= 1'b0;
      hs_wdata <= lcdr_pkg::DATA_RESET;
    end else if (i_ce) begin
      if (in_init) begin
        hs_state <= lcdr_pkg::HS_IDLE;
        hs_rs <= 1'b0;
        hs_wdata <= lcdr_pkg::DATA_RESET;
      end else begin
        unique case (hs_state)
          lcdr_pkg::HS_IDLE: begin
            // A strobe still low when chip init ends is taken as a new access
            hs_rs <= i_reg_select;
            hs_wdata <= i_data;
            if (bus_wr) begin
              hs_state <= lcdr_pkg::HS_WRITE;
            end else if (bus_rd) begin
              hs_state <= lcdr_pkg::HS_READ;
            end
          end
          lcdr_pkg::HS_WRITE: begin
            if (bus_wr) begin
              hs_wdata <= i_data;
            end else begin
              hs_state <= lcdr_pkg::HS_IDLE;
            end
          end
          lcdr_pkg::HS_READ: begin
            if (!bus_rd) begin
              hs_state <= (hs_rs & ram_selected & data_reg_open) ? lcdr_pkg::HS_FETCH :
                          lcdr_pkg::HS_IDLE;
            end
          end
          lcdr_pkg::HS_FETCH: begin
            hs_state <= lcdr_pkg::HS_IDLE;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Index register
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      index_select <= lcdr_pkg::INDEX_RESET;
    end else if (i_ce) begin
      if (in_init) begin
        index_select <= lcdr_pkg::INDEX_RESET;
      end else if (commit_index) begin
        index_select <= hs_wdata[4:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  always_comb begin
    next_control_one = lcdr_pkg::lcdr_ctl1_t'(hs_wdata);
    // Entering sleep drops the panel-on bit; everything else is kept
    if (next_control_one.sleep_mode) begin
      next_control_one.panel_on = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      control_one <= lcdr_pkg::CTL1_RESET;
      control_two <= lcdr_pkg::CTL2_RESET;
    end else if (i_ce) begin
      if (in_init) begin
        control_one <= lcdr_pkg::CTL1_RESET;
        control_two <= lcdr_pkg::CTL2_RESET;
      end else if (commit_data) begin
        if (index_select == lcdr_pkg::IDX_CONTROL_ONE) begin
          control_one <= next_control_one;
        end
        if (index_select == lcdr_pkg::IDX_CONTROL_TWO) begin
          control_two <= lcdr_pkg::lcdr_ctl2_t'(hs_wdata);
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // RAM addresses: direct writes and auto advance
  // ---------------------------------------------------------------
  // Both addresses wrap to zero past their own limit rather than stick
  logic step_now;
  assign step_now = ram_access_wr |
                    ((hs_state == lcdr_pkg::HS_FETCH) & ~control_one.write_only_step);

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      column_address <= lcdr_pkg::COLUMN_RESET;
      line_address <= lcdr_pkg::RASTER_RESET;
    end else if (i_ce) begin
      if (in_init) begin
        column_address <= lcdr_pkg::COLUMN_RESET;
        line_address <= lcdr_pkg::RASTER_RESET;
      end else if (commit_data & data_reg_open &
                   (index_select == lcdr_pkg::IDX_COLUMN_ADDR)) begin
        // Out of range values are dropped, not clipped
        if (hs_wdata[7:6] == 2'b00 && hs_wdata[5:0] <= column_limit) begin
          column_address <= hs_wdata[5:0];
        end
      end else if (commit_data & data_reg_open &
                   (index_select == lcdr_pkg::IDX_LINE_ADDR)) begin
        if (!hs_wdata[7] && hs_wdata[6:0] <= lcdr_pkg::LINE_MAX) begin
          line_address <= hs_wdata[6:0];
        end
      end else if (step_now) begin
        if (control_two.step_column) begin
          column_address <= (column_address >= column_limit) ? lcdr_pkg::COLUMN_RESET :
                            6'(column_address + 6'h01);
        end else begin
          line_address <= (line_address >= lcdr_pkg::LINE_MAX) ? lcdr_pkg::RASTER_RESET :
                          7'(line_address + 7'h01);
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Raster registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      top_raster <= lcdr_pkg::RASTER_RESET;
      flash_first_raster <= lcdr_pkg::RASTER_RESET;
      flash_last_raster <= lcdr_pkg::RASTER_RESET;
    end else if (i_ce) begin
      if (in_init) begin
        top_raster <= lcdr_pkg::RASTER_RESET;
        flash_first_raster <= lcdr_pkg::RASTER_RESET;
        flash_last_raster <= lcdr_pkg::RASTER_RESET;
      end else if (commit_data & data_reg_open) begin
        // Bit 7 is unused in all three; register numbers 8 to 17 land nowhere
        if (index_select == lcdr_pkg::IDX_TOP_RASTER) begin
          top_raster <= hs_wdata[6:0];
        end
        if (index_select == lcdr_pkg::IDX_FLASH_FIRST) begin
          flash_first_raster <= hs_wdata[6:0];
        end
        if (index_select == lcdr_pkg::IDX_FLASH_LAST) begin
          flash_last_raster <= hs_wdata[6:0];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Read latch: a read returns what the previous read fetched
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      read_latch <= lcdr_pkg::DATA_RESET;
    end else if (i_ce) begin
      if (in_init) begin
        read_latch <= lcdr_pkg::DATA_RESET;
      end else if (hs_state == lcdr_pkg::HS_FETCH) begin
        // Only a RAM fetch loads it; reads of other registers leave it alone
        read_latch <= control_two.word_size_sel ? {2'b00, i_ram_rdata[5:0]} :
                      i_ram_rdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // Blink counter, advanced by frame ticks
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      flash_count <= 6'h00;
      flash_phase <= 1'b0;
    end else if (i_ce) begin
      // Phase clears with the count, so a re-enable always starts shown
      if (in_init || !control_two.flash_enable) begin
        flash_count <= 6'h00;
        flash_phase <= 1'b0;
      end else if (running && i_frame_tick) begin
        flash_count <= 6'(flash_count + 6'h01);
        if (flash_count == lcdr_pkg::FLASH_FRAMES_LAST) begin
          flash_phase <= ~flash_phase;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Decoded drive settings
  // ---------------------------------------------------------------
  always_comb begin
    o_drive.grey_fixed = control_two.grey_fixed;
    o_drive.invert_pixels = control_one.invert_pixels;
    o_drive.column_reverse = control_one.column_reverse;
    o_drive.six_bit_words = control_two.word_size_sel;
    // Partial display rides on the 1/8 duty code; there is no bit of its own
    o_drive.partial_mode = (control_two.duty_sel == 2'b11);
    unique case (control_two.divider_ratio)
      2'b11: o_drive.bias_denominator = lcdr_pkg::BIAS_DIV_8;
      2'b10: o_drive.bias_denominator = lcdr_pkg::BIAS_DIV_9;
      2'b01: o_drive.bias_denominator = lcdr_pkg::BIAS_DIV_10;
      2'b00: o_drive.bias_denominator = lcdr_pkg::BIAS_DIV_11;
    endcase
    unique case (control_two.duty_sel)
      2'b11: o_drive.duty_rows = lcdr_pkg::DUTY_ROWS_8;
      2'b10: o_drive.duty_rows = lcdr_pkg::DUTY_ROWS_64;
      2'b01: o_drive.duty_rows = lcdr_pkg::DUTY_ROWS_80;
      2'b00: o_drive.duty_rows = lcdr_pkg::DUTY_ROWS_100;
    endcase
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign o_data = read_latch;
  assign o_data_oe = (hs_state == lcdr_pkg::HS_READ);
  assign o_ram_column = column_address;
  assign o_ram_line = line_address;
  assign o_ram_wr = ram_access_wr;
  assign o_ram_wdata = wmasked;
  assign o_ram_rd = (hs_state == lcdr_pkg::HS_READ) & ~bus_rd & hs_rs & ram_selected &
                    data_reg_open;
  // Drivers sit at the drive level in reset, with panel off or in sleep
  assign o_drivers_off = in_init | ~control_one.panel_on | control_one.sleep_mode;
  // No alternation in reset keeps DC off the liquid crystal
  assign o_alternate_hold = in_init;
  assign o_osc_run = ~control_one.sleep_mode;
  assign o_internal_run = running;
  // The host sequences the panel supply; the pin simply follows the bit
  assign o_supply_switch_out = control_one.ext_supply_ctl;
  assign o_bias_amp_en = control_one.bias_amp_en;
  assign o_flash_blank = control_two.flash_enable & flash_phase;
  assign o_top_raster = top_raster;
  assign o_flash_first = flash_first_raster;
  assign o_flash_last = flash_last_raster;

endmodule

`default_nettype wire

// ---- sim/lcdr_ram_model.sv ----
// Display RAM model with one cycle of read latency
`timescale 1ns/1ps
`default_nettype none

module lcdr_ram_model (
  // Clock
  input wire logic i_ref_clk,
  // Access port from the register bank
  input wire logic [5:0] i_column,
  input wire logic [6:0] i_line,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  input wire logic i_rd,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [int];

  initial o_rdata = 8'h00;

  always @(posedge i_ref_clk) begin
    if (i_wr) begin
      mem[int'({i_column, i_line})] = i_wdata;
    end
    // Data holds one cycle only; churning afterwards exposes late sampling
    if (i_rd) begin
      // Cells never written read as zero, as the bench model assumes
      o_rdata <= mem.exists(int'({i_column, i_line})) ?
                 mem[int'({i_column, i_line})] : 8'h00;
    end else begin
      o_rdata <= ~o_rdata;
    end
  end
endmodule

`default_nettype wire

// ---- sim/lcdr_top_chk.sv ----
// Port checker for the LCD controller register bank
`timescale 1ns/1ps
`default_nettype none

module lcdr_top_chk (
  // Clock, reset, enable
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Watched inputs
  input wire logic i_chip_init_n,
  input wire logic i_wr_n,
  input wire logic i_frame_tick,
  // Watched outputs
  input wire logic [7:0] o_data,
  input wire logic o_data_oe,
  input wire logic [5:0] o_ram_column,
  input wire logic [6:0] o_ram_line,
  input wire logic o_ram_wr,
  input wire logic o_ram_rd,
  input wire logic o_drivers_off,
  input wire logic o_alternate_hold,
  input wire logic o_osc_run,
  input wire logic o_internal_run,
  input wire logic o_flash_blank,
  input wire lcdr_pkg::lcdr_drive_t o_drive
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  property p_init_off;
    !i_chip_init_n |-> o_drivers_off && o_alternate_hold;
  endproperty
  a_init_off: assert property (p_init_off)
    else $error("drivers not held off during chip init");

  property p_init_quiet;
    $past(!i_chip_init_n && i_ce) && !i_chip_init_n |-> !o_ram_wr && !o_ram_rd && !o_data_oe;
  endproperty
  a_init_quiet: assert property (p_init_quiet)
    else $error("host access served during chip init");

  property p_drive_codes;
    (o_drive.duty_rows inside {7'h08, 7'h40, 7'h50, 7'h64}) &&
    (o_drive.partial_mode == (o_drive.duty_rows == 7'h08)) &&
    (o_drive.bias_denominator inside {[4'h8:4'hB]});
  endproperty
  a_drive_codes: assert property (p_drive_codes)
    else $error("illegal bias or duty decode");

  property p_sleep;
    !o_osc_run |-> !o_internal_run && o_drivers_off;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep without halt and blanking");

  property p_line_max;
    o_ram_line <= 7'h40;
  endproperty
  a_line_max: assert property (p_line_max)
    else $error("line address above limit");

  property p_rd_cause;
    o_ram_rd && i_ce |-> o_data_oe ##1 (!o_ram_rd && !o_data_oe);
  endproperty
  a_rd_cause: assert property (p_rd_cause)
    else $error("RAM fetch without host read");

  property p_oe_hold;
    o_data_oe && $past(o_data_oe) |-> $stable(o_data);
  endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("read data moved while driven");

  property p_wr_cause;
    o_ram_wr |-> $past(!i_wr_n) || $past(!i_wr_n, 2);
  endproperty
  a_wr_cause: assert property (p_wr_cause)
    else $error("RAM write without host strobe");

  property p_wr_step;
    o_ram_wr && i_ce |-> ##[1:2] ($changed(o_ram_column) || $changed(o_ram_line));
  endproperty
  a_wr_step: assert property (p_wr_step)
    else $error("address did not advance after RAM write");

  property p_blank_tick;
    $rose(o_flash_blank) |-> $past(i_frame_tick) || $past(i_frame_tick, 2);
  endproperty
  a_blank_tick: assert property (p_blank_tick)
    else $error("blink phase changed without frame tick");

  c_ram_wr: cover property (o_ram_wr);
  c_ram_rd: cover property (o_ram_rd);
  c_blank: cover property ($rose(o_flash_blank));
endmodule

bind lcdr_top lcdr_top_chk u_chk (.i_ref_clk, .i_rst, .i_ce, .i_chip_init_n, .i_wr_n,
  .i_frame_tick, .o_data, .o_data_oe, .o_ram_column, .o_ram_line, .o_ram_wr, .o_ram_rd,
  .o_drivers_off, .o_alternate_hold, .o_osc_run, .o_internal_run, .o_flash_blank, .o_drive);

`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking testbench for the LCD controller register bank
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_chip_init_n = 1'b1;
  logic i_cs_n = 1'b1;
  logic i_reg_select = 1'b0;
  logic i_wr_n = 1'b1;
  logic i_rd_n = 1'b1;
  logic [7:0] i_data = 8'h00;
  logic i_frame_tick = 1'b0;
  logic [7:0] o_data, o_ram_wdata, ram_rdata;
  logic o_data_oe, o_ram_wr, o_ram_rd, o_drivers_off, o_alternate_hold, o_osc_run;
  logic o_internal_run, o_supply_switch_out, o_bias_amp_en, o_flash_blank;
  logic [5:0] o_ram_column;
  logic [6:0] o_ram_line, o_top_raster, o_flash_first, o_flash_last;
  lcdr_pkg::lcdr_drive_t o_drive;
  int error_cnt = 0;
  int check_count = 0;
  integer seed = 32'h2762;
  int c1 = 0, c2 = 0, x = 0, y = 0, idx = 0, latch = 0, i;
  int ras[3] = '{0, 0, 0};
  int duty[4] = '{100, 80, 64, 8};
  int mem[int];

  always #5 i_ref_clk = ~i_ref_clk;

  lcdr_top dut (.i_ref_clk, .i_rst, .i_ce(1'b1), .i_chip_init_n, .i_cs_n, .i_reg_select,
    .i_wr_n, .i_rd_n, .i_data, .o_data, .o_data_oe, .o_ram_column, .o_ram_line, .o_ram_wr,
    .o_ram_wdata, .o_ram_rd, .i_ram_rdata(ram_rdata), .i_frame_tick, .o_drivers_off,
    .o_alternate_hold, .o_osc_run, .o_internal_run, .o_supply_switch_out, .o_bias_amp_en,
    .o_flash_blank, .o_drive, .o_top_raster, .o_flash_first, .o_flash_last);
  lcdr_ram_model ram (.i_ref_clk, .i_column(o_ram_column), .i_line(o_ram_line),
    .i_wr(o_ram_wr), .i_wdata(o_ram_wdata), .i_rd(o_ram_rd), .o_rdata(ram_rdata));

  // ---------------------------------------------------------------
  // Comparison, model and bus tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  function automatic int lim();
    return c2[5] ? 'h35 : 'h27;
  endfunction

  // Address wraps to zero past its limit
  task automatic step();
    if (c2[1]) x = (x == lim()) ? 0 : x + 1;
    else y = (y == 'h40) ? 0 : y + 1;
  endtask

  task automatic check_all();
    chk("address", {x[5:0], y[6:0]}, {o_ram_column, o_ram_line});
    chk("power", {!c1[6] | c1[5], !c1[5], !(c1[5] | c1[1]), c1[4], c1[3]},
      {o_drivers_off, o_osc_run, o_internal_run, o_supply_switch_out, o_bias_amp_en});
    chk("drive", {4'(11 - c2[7:6]), 7'(duty[c2[3:2]]), c2[3:2] == 2'b11, c2[4], c1[2], c1[0],
      c2[5]}, o_drive);
    chk("raster", {ras[0][6:0], ras[1][6:0], ras[2][6:0]},
      {o_top_raster, o_flash_first, o_flash_last});
  endtask

  // Strobe held two edges, then four idle edges cover commit and fetch
  task automatic bus(input logic rs, input logic rd, input logic [7:0] d);
    i_cs_n = 1'b0;
    i_reg_select = rs;
    i_rd_n = !rd;
    i_wr_n = rd;
    i_data = d;
    repeat (2) @(posedge i_ref_clk);
    #1;
    if (rd) chk("read_data", latch, o_data);
    chk("data_oe", rd, o_data_oe);
    i_cs_n = 1'b1;
    i_rd_n = 1'b1;
    i_wr_n = 1'b1;
    repeat (4) @(posedge i_ref_clk);
    #1;
  endtask

  task automatic wr(input logic rs, input int v);
    bus(rs, 1'b0, v[7:0]);
    if (!rs) idx = v & 'h1F;
    else if (!(c1[5] && idx > 1)) begin
      case (idx)
        0: c1 = v[5] ? (v & 'hBF) : (v & 'hFF);
        1: c2 = v & 'hFF;
        2: if (v <= lim()) x = v;
        3: if (v <= 'h40) y = v;
        4: begin
          mem[x * 128 + y] = v & (c2[5] ? 'h3F : 'hFF);
          step();
        end
        5, 6, 7: ras[idx - 5] = v & 'h7F;
        default: ;
      endcase
    end
    check_all();
  endtask

  task automatic rd();
    bus(1'b1, 1'b1, 8'h00);
    latch = mem.exists(x * 128 + y) ? mem[x * 128 + y] : 0;
    latch = latch & (c2[5] ? 'h3F : 'hFF);
    if (!c1[7]) step();
    check_all();
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      i_frame_tick = 1'b1;
      @(posedge i_ref_clk);
      #1;
      i_frame_tick = 1'b0;
      @(posedge i_ref_clk);
      #1;
    end
  endtask

  task automatic end_of_test();
    if (error_cnt == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge i_ref_clk);
    #1;
    i_rst = 1'b0;
    @(posedge i_ref_clk);
    #1;
    check_all();
    wr(0, 1);
    for (i = 0; i < 16; i++) wr(1, {i[3:0], i[1:0], 2'b00});
    wr(0, 0);
    repeat (8) wr(1, $random(seed) & 'hDF);
    wr(1, 'h7F);
    wr(0, 3);
    wr(1, 'h10);
    wr(0, 0);
    wr(1, 'h40);
    for (i = 0; i < 2; i++) begin
      wr(0, 1);
      wr(1, i * 'h20);
      wr(0, 2);
      wr(1, 'h27 + i * 'h0E);
      wr(1, 'h28 + i * 'h0E);
      wr(1, 'hC0);
    end
    wr(0, 3);
    wr(1, 'h40);
    wr(1, 'h41);
    for (i = 0; i < 4; i++) begin
      wr(0, 0);
      wr(1, 'h40 | (i[0] << 7));
      wr(0, 1);
      wr(1, i[1] * 2 + i[0] * 'h20);
      wr(0, 2);
      wr(1, lim());
      wr(0, 3);
      wr(1, 'h3F);
      wr(0, 4);
      repeat (3) wr(1, $random(seed));
      wr(0, 2);
      wr(1, lim());
      wr(0, 3);
      wr(1, 'h3F);
      wr(0, 4);
      repeat (4) rd();
    end
    wr(0, 9);
    wr(1, 'hFF);
    wr(0, 5);
    wr(1, 'h92);
    wr(0, 6);
    wr(1, 'h20);
    wr(0, 7);
    wr(1, 'h28);
    wr(0, 1);
    wr(1, 'h01);
    tick(63);
    chk("blank", 0, o_flash_blank);
    tick(1);
    chk("blank", 1, o_flash_blank);
    wr(1, 'h00);
    chk("blank", 0, o_flash_blank);
    i_chip_init_n = 1'b0;
    @(posedge i_ref_clk);
    #1;
    chk("init_pins", 2'b11, {o_drivers_off, o_alternate_hold});
    bus(1'b1, 1'b0, 8'h10);
    i_chip_init_n = 1'b1;
    {c1, c2, x, y, idx, latch} = '0;
    ras = '{0, 0, 0};
    @(posedge i_ref_clk);
    #1;
    check_all();
    wr(1, 'h48);
    wr(0, 4);
    rd();
    end_of_test();
  end

  initial begin
    #400000;
    error_cnt++;
    end_of_test();
  end
endmodule

`default_nettype wire
